// *** aux_adc_step_regs.sv ***
// Step 14 and step 15 configuration registers with a small step sequencer
//
// Contract
// R1: Bit 15 enables step 14, resets cleared
// R2: Gain code 00=1, 01=2, 10/11=4
// R3: Bits 12:5 reserved, always read zero
// R4: Bit 4 picks ground or input 7
// R5: Positive codes 0-7 pick external inputs 0-7
// R6: Codes 8,9,A: temp, short, test DAC
// R7: Upper codes are supply monitors; E analog power
// R8: Automatic negative code ignores negative select bit
// R9: Step 15 at DF, reset 000F
// R10: Step 14 positive field resets to 1110
// R11: Step 14 at DE, reset 000E
// R12: Skip disabled steps, apply enabled step settings
// R13: Unsettled upper supply codes are flagged
`timescale 1ns/100ps
`default_nettype none
`include "aux_adc_seq_defines.svh"
module aux_adc_step_regs
   import aux_adc_seq_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata,
   output logic             reg_rd_unmapped,
   // Sequencer control from the converter
   input  wire logic        seq_start,
   input  wire logic        conv_done,
   // Conversion request and its settings
   output logic             conv_req,
   output logic [3:0]       conv_step,
   output logic [2:0]       conv_gain_factor,
   output var pos_kind_t    conv_pos_kind,
   output logic [2:0]       conv_ext_index,
   output logic             conv_neg_input7,
   output logic             conv_neg_auto,
   output logic             conv_code_unresolved,
   // Sequencer status
   output logic             seq_busy,
   output logic             seq_done
);

   // Merges a write into a step register; reserved bits never take data
   // Shared by both step registers so the mask lives in one place
   function automatic logic [15:0] cfg_merge(input logic [15:0] wdata);
      cfg_merge = wdata & `CFG_WRITE_MASK;                       // R3
   endfunction : cfg_merge

   // Stored step registers
   logic [15:0] step14_cfg_q;       // Step 14 configuration
   logic [15:0] step15_cfg_q;       // Step 15 configuration

   // Read path registers
   logic [15:0] rdata_q;            // Read data, one cycle after the strobe
   logic [15:0] rdata_d;            // Next read data
   logic        unmapped_q;         // Read hit no register
   logic        unmapped_d;         // Next unmapped flag

   // Address decode
   logic        hit14;              // Address is step 14
   logic        hit15;              // Address is step 15

   // Write enables
   logic        wr14;               // Write lands in step 14
   logic        wr15;               // Write lands in step 15

   // Decoded routing of step 14
   logic        step14_enable;      // Step 14 taking part
   logic [2:0]  step14_gain;        // Step 14 gain factor
   pos_kind_t   step14_kind;        // Step 14 positive kind
   logic [2:0]  step14_ext;         // Step 14 external index
   logic        step14_neg7;        // Step 14 negative on input 7
   logic        step14_auto;        // Step 14 negative automatic
   logic        step14_unres;       // Step 14 unsettled code

   // Decoded routing of step 15
   logic        step15_enable;      // Step 15 taking part
   logic [2:0]  step15_gain;        // Step 15 gain factor
   pos_kind_t   step15_kind;        // Step 15 positive kind
   logic [2:0]  step15_ext;         // Step 15 external index
   logic        step15_neg7;        // Step 15 negative on input 7
   logic        step15_auto;        // Step 15 negative automatic
   logic        step15_unres;       // Step 15 unsettled code

   // Sequencer state
   seq_state_t  state_q;            // Current step
   seq_state_t  state_d;            // Next step
   logic        enter14;            // Step 14 begins this cycle
   logic        enter15;            // Step 15 begins this cycle
   logic        finish;             // Sequence ends this cycle

   // Conversion snapshot registers
   logic        req_q;              // Request pulse
   logic [3:0]  step_q;             // Step number
   logic [2:0]  gain_q;             // Gain factor
   pos_kind_t   kind_q;             // Positive kind
   logic [2:0]  ext_q;              // External index
   logic        neg7_q;             // Negative on input 7
   logic        auto_q;             // Negative automatic
   logic        unres_q;            // Unsettled code
   logic        busy_q;             // Sequence running
   logic        done_q;             // Sequence finished pulse

   // Address decode
   assign hit14 = (reg_addr == `STEP14_CONFIG_ADDR);             // R11
   assign hit15 = (reg_addr == `STEP15_CONFIG_ADDR);             // R9

   // Write enables; only the two step addresses are decoded,
   // so a write anywhere else is dropped
   assign wr14 = reg_wr && hit14;                                // R11
   assign wr15 = reg_wr && hit15;                                // R9

   // Step 14 register; reset preloads the analog power monitor code
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step14_cfg_q <= `STEP14_CONFIG_RESET;                   // R1 R10 R11
      end else if (wr14) begin
         // Reserved bits are cleared on the way in
         step14_cfg_q <= cfg_merge(reg_wdata);                   // R3
      end
   end

   // Step 15 register
   // Same layout as step 14, only the reset code differs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step15_cfg_q <= `STEP15_CONFIG_RESET;                   // R9
      end else if (wr15) begin
         // Reserved bits are cleared on the way in
         step15_cfg_q <= cfg_merge(reg_wdata);                   // R3
      end
   end

   // Read mux; data stand only in the cycle after the strobe
   always_comb begin
      // Nothing read: the bus rests at zero
      rdata_d    = 16'h0000;
      unmapped_d = 1'b0;
      if (reg_rd) begin
         if (hit14) begin
            // Reserved bits were never stored, so they read zero
            rdata_d = step14_cfg_q;                              // R3
         end else if (hit15) begin
            // Same for step 15
            rdata_d = step15_cfg_q;                              // R3
         end else begin
            // Unknown address reads zero and is flagged
            unmapped_d = 1'b1;
         end
      end
   end

   // Read data register; falls back to zero once the slot has passed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;                                     // R3
      end
   end

   // Unmapped read flag, a one-cycle pulse beside the read data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unmapped_q <= 1'b0;
      end else begin
         unmapped_q <= unmapped_d;
      end
   end

   // Routing decode of step 14
   // Decoded live from the stored word; captured only at step entry
   step_route_decode u_dec14 (
      .cfg         (step14_cfg_q),
      .enabled     (step14_enable),
      .gain_factor (step14_gain),
      .pos_kind    (step14_kind),
      .ext_index   (step14_ext),
      .neg_input7  (step14_neg7),
      .neg_auto    (step14_auto),
      .unresolved  (step14_unres)
   );

   // Routing decode of step 15
   // Decoded live from the stored word; captured only at step entry
   step_route_decode u_dec15 (
      .cfg         (step15_cfg_q),
      .enabled     (step15_enable),
      .gain_factor (step15_gain),
      .pos_kind    (step15_kind),
      .ext_index   (step15_ext),
      .neg_input7  (step15_neg7),
      .neg_auto    (step15_auto),
      .unresolved  (step15_unres)
   );

   // Sequencer next state; disabled steps are passed over
   // A write in the start cycle is seen from the next cycle on
   always_comb begin
      state_d = state_q;
      enter14 = 1'b0;
      enter15 = 1'b0;
      finish  = 1'b0;
      // State codes are one-hot; anything else is illegal
      unique case (state_q)
         SEQ_IDLE: begin
            // Start is only taken here, so a start while busy is ignored
            if (seq_start) begin
               if (step14_enable) begin
                  state_d = SEQ_STEP14;                          // R12
                  enter14 = 1'b1;
               end else if (step15_enable) begin
                  state_d = SEQ_STEP15;                          // R12
                  enter15 = 1'b1;
               end else begin
                  // Nothing enabled: finish at once
                  finish = 1'b1;                                 // R12
               end
            end
         end
         SEQ_STEP14: begin
            // Step 14 always runs before step 15
            if (conv_done) begin
               if (step15_enable) begin
                  state_d = SEQ_STEP15;                          // R12
                  enter15 = 1'b1;
               end else begin
                  state_d = SEQ_IDLE;                            // R12
                  finish  = 1'b1;
               end
            end
         end
         SEQ_STEP15: begin
            // Last step; its done ends the sequence
            if (conv_done) begin
               state_d = SEQ_IDLE;
               finish  = 1'b1;
            end
         end
         default: begin
            // Illegal code falls back to idle
            state_d = SEQ_IDLE;
         end
      endcase
   end

   // Sequencer state register
   // Illegal codes are caught by the default branch above
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SEQ_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Request pulse, one cycle at the start of each step
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_q <= 1'b0;
      end else begin
         req_q <= enter14 || enter15;                            // R12
      end
   end

   // Running flag follows the next state, so it rises with the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_d != SEQ_IDLE);
      end
   end

   // Done pulse; also given when no step is enabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
      end else begin
         done_q <= finish;                                       // R12
      end
   end

   // Settings are captured when a step begins, so a write during the
   // conversion cannot change the routing half way through
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step_q  <= 4'h0;
         gain_q  <= `GAIN_FACTOR_X1;
         kind_q  <= POS_EXTERNAL;
         ext_q   <= 3'h0;
         neg7_q  <= 1'b0;
         auto_q  <= 1'b0;
         unres_q <= 1'b0;
      end else if (enter14) begin
         // Step 14 settings frozen for its conversion
         step_q  <= `STEP_NUM_14;
         gain_q  <= step14_gain;                                 // R12 R2
         kind_q  <= step14_kind;                                 // R12
         ext_q   <= step14_ext;                                  // R5
         neg7_q  <= step14_neg7;                                 // R8
         auto_q  <= step14_auto;                                 // R6
         unres_q <= step14_unres;                                // R13
      end else if (enter15) begin
         // Step 15 settings frozen for its conversion
         step_q  <= `STEP_NUM_15;
         gain_q  <= step15_gain;                                 // R12 R2
         kind_q  <= step15_kind;                                 // R12
         ext_q   <= step15_ext;                                  // R5
         neg7_q  <= step15_neg7;                                 // R8
         auto_q  <= step15_auto;                                 // R6
         unres_q <= step15_unres;                                // R13
      end
   end

   // Outputs straight from flip-flops,
   // so the converter never sees decode glitches
   assign reg_rdata            = rdata_q;
   assign reg_rd_unmapped      = unmapped_q;

   // Conversion request and its frozen settings
   assign conv_req             = req_q;
   assign conv_step            = step_q;
   assign conv_gain_factor     = gain_q;
   assign conv_pos_kind        = kind_q;
   assign conv_ext_index       = ext_q;
   assign conv_neg_input7      = neg7_q;
   assign conv_neg_auto        = auto_q;
   assign conv_code_unresolved = unres_q;

   // Sequencer status
   assign seq_busy             = busy_q;
   assign seq_done             = done_q;

endmodule : aux_adc_step_regs
`default_nettype wire

// *** aux_adc_seq_defines.svh ***
// Offsets, field positions, reset values and codes of the late sequencer steps
`ifndef AUX_ADC_SEQ_DEFINES_SVH
`define AUX_ADC_SEQ_DEFINES_SVH

// Register addresses on the register port
`define STEP14_CONFIG_ADDR   8'hDE
`define STEP15_CONFIG_ADDR   8'hDF

// Reset values of the two step registers
`define STEP14_CONFIG_RESET  16'h000E
`define STEP15_CONFIG_RESET  16'h000F

// Field positions inside a step register
`define CFG_ENABLE_BIT       15
`define CFG_GAIN_HI          14
`define CFG_GAIN_LO          13
`define CFG_RSVD_HI          12
`define CFG_RSVD_LO          5
`define CFG_NEG_BIT          4
`define CFG_POS_HI           3
`define CFG_POS_LO           0

// Bits that software may write; reserved bits stay zero
`define CFG_WRITE_MASK       16'hE01F

// Gain field codes and the factors they give
`define GAIN_CODE_X1         2'h0
`define GAIN_CODE_X2         2'h1
`define GAIN_FACTOR_X1       3'h1
`define GAIN_FACTOR_X2       3'h2
`define GAIN_FACTOR_X4       3'h4

// Positive-input codes with a fixed meaning
`define POS_CODE_TEMP        4'h8
`define POS_CODE_SHORT       4'h9
`define POS_CODE_TEST_DAC    4'hA
`define POS_CODE_ANALOG_POWER_INPUT_DIV    4'hE

// Step numbers reported with a conversion request
`define STEP_NUM_14          4'hE
`define STEP_NUM_15          4'hF

`endif

// *** aux_adc_seq_pkg.sv ***
// Types shared by the step decoder and the step register bank
`default_nettype none
package aux_adc_seq_pkg;

   // Kind of source on the positive converter input
   typedef enum logic [2:0] {
      POS_EXTERNAL     = 3'h0,
      POS_TEMP_SENSOR  = 3'h1,
      POS_GROUND_SHORT = 3'h2,
      POS_TEST_DAC     = 3'h3,
      POS_SUPPLY_MON   = 3'h4
   } pos_kind_t;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      SEQ_IDLE   = 3'b001,
      SEQ_STEP14 = 3'b010,
      SEQ_STEP15 = 3'b100
   } seq_state_t;

endpackage : aux_adc_seq_pkg
`default_nettype wire

// *** step_route_decode.sv ***
// Decodes one step register into gain and input routing
`timescale 1ns/100ps
`default_nettype none
`include "aux_adc_seq_defines.svh"
module step_route_decode
   import aux_adc_seq_pkg::*;
(
   // Step register contents
   input  wire logic [15:0] cfg,
   // Decoded routing
   output logic             enabled,
   output logic [2:0]       gain_factor,
   output var pos_kind_t    pos_kind,
   output logic [2:0]       ext_index,
   output logic             neg_input7,
   output logic             neg_auto,
   output logic             unresolved
);

   logic [3:0] pos_code;   // Positive-input field
   logic [1:0] gain_code;  // Gain field

   assign pos_code  = cfg[`CFG_POS_HI:`CFG_POS_LO];
   assign gain_code = cfg[`CFG_GAIN_HI:`CFG_GAIN_LO];
   assign enabled   = cfg[`CFG_ENABLE_BIT];
   assign ext_index = pos_code[2:0];

   // Gain: both upper codes give the largest factor
   always_comb begin
      unique case (gain_code)
         `GAIN_CODE_X1: gain_factor = `GAIN_FACTOR_X1;  // R2
         `GAIN_CODE_X2: gain_factor = `GAIN_FACTOR_X2;  // R2
         default:       gain_factor = `GAIN_FACTOR_X4;  // R2
      endcase
   end

   // Every code from the temperature sensor upward picks its own negative input
   assign neg_auto   = pos_code[3];                              // R6
   // Negative select bit only counts for external inputs
   assign neg_input7 = !neg_auto && cfg[`CFG_NEG_BIT];           // R4 R8

   // Positive source kind
   always_comb begin
      if (!pos_code[3]) begin
         pos_kind = POS_EXTERNAL;                                // R5
      end else if (pos_code == `POS_CODE_TEMP) begin
         pos_kind = POS_TEMP_SENSOR;                             // R6
      end else if (pos_code == `POS_CODE_SHORT) begin
         pos_kind = POS_GROUND_SHORT;                            // R6
      end else if (pos_code == `POS_CODE_TEST_DAC) begin
         pos_kind = POS_TEST_DAC;                                // R6
      end else begin
         pos_kind = POS_SUPPLY_MON;                              // R7
      end
   end

   // Only the analog power divider is a settled supply code; the rest are flagged
   assign unresolved = (pos_kind == POS_SUPPLY_MON) &&
                       (pos_code != `POS_CODE_ANALOG_POWER_INPUT_DIV);         // R7 R13

endmodule : step_route_decode
`default_nettype wire

// *** step_regs_checker_props.sv ***
// Port checker for the step register bank and its sequencer
`timescale 1ns/100ps
`default_nettype none
module step_regs_checker
   import aux_adc_seq_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Register read port
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_rdata,
   // Sequencer side
   input  wire logic        seq_start,
   input  wire logic        conv_req,
   input  wire logic [3:0]  conv_step,
   input  wire logic [2:0]  conv_gain_factor,
   input  var  pos_kind_t   conv_pos_kind,
   input  wire logic        conv_neg_input7,
   input  wire logic        conv_neg_auto,
   input  wire logic        conv_code_unresolved,
   input  wire logic        seq_busy,
   input  wire logic        seq_done
);
   // Single domain, so one clock and one reset for all
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Read data is zero outside its slot
   idle_read_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data seen outside read slot");
   rsvd_zero_a: assert property (reg_rd |=> reg_rdata[12:5] == 8'h00)
      else $error("reserved bits read nonzero");
   gain_legal_a: assert property (conv_req |-> conv_gain_factor inside {3'h1, 3'h2, 3'h4})
      else $error("gain factor not 1, 2 or 4");
   auto_kind_a: assert property (conv_req |-> conv_neg_auto == (conv_pos_kind != POS_EXTERNAL))
      else $error("auto negative does not match source kind");
   neg_ignored_a: assert property (conv_neg_auto |-> !conv_neg_input7)
      else $error("negative select used under auto selection");
   unres_kind_a: assert property (conv_code_unresolved |-> conv_pos_kind == POS_SUPPLY_MON)
      else $error("unresolved flag on non-supply code");
   req_step_a: assert property (conv_req |-> seq_busy && conv_step inside {4'hE, 4'hF} ##1 !conv_req)
      else $error("conversion request malformed");
   start_ans_a: assert property (seq_start && !seq_busy |-> ##[1:2] (seq_busy || seq_done))
      else $error("start not answered");
   done_idle_a: assert property (seq_done |-> !seq_busy ##1 !seq_done)
      else $error("done pulse while busy or too long");
endmodule : step_regs_checker

bind aux_adc_step_regs step_regs_checker step_regs_checker_inst (
   .clk, .rst_n, .reg_rd, .reg_rdata, .seq_start, .conv_req, .conv_step,
   .conv_gain_factor, .conv_pos_kind, .conv_neg_input7, .conv_neg_auto,
   .conv_code_unresolved, .seq_busy, .seq_done
);
`default_nettype wire

// *** aux_adc_step_regs_tb_top.sv ***
// Self-checking bench for the step register bank
`timescale 1ns/100ps
`default_nettype none
module aux_adc_step_regs_tb_top
   import aux_adc_seq_pkg::*;
   ;
   // Case row: config word and packed expected settings
   typedef struct packed {logic [15:0] cfg; logic [15:0] exp;} row_t;
   // Inputs, all given a value at time zero
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        seq_start = 1'b0;
   logic        conv_done = 1'b0;
   // Outputs
   logic [15:0] reg_rdata;
   logic        reg_rd_unmapped, conv_req, conv_neg_input7, conv_neg_auto;
   logic [3:0]  conv_step;
   logic [2:0]  conv_gain_factor, conv_ext_index;
   pos_kind_t   conv_pos_kind;
   logic        conv_code_unresolved, seq_busy, seq_done;
   // Counters
   int          n_fail = 0;
   int          checked = 0;
   int          cycles = 0;
   // Expected: step, gain, kind, index, neg7, auto, unresolved
   row_t        rows [8] = '{'{16'h8000, 16'hE200}, '{16'hA017, 16'hE43C},
                             '{16'hC018, 16'hE842}, '{16'hE1F9, 16'hE88A},
                             '{16'h801A, 16'hE2D2}, '{16'h801E, 16'hE332},
                             '{16'h800B, 16'hE31B}, '{16'h8013, 16'hE21C}};

   aux_adc_step_regs aux_adc_step_regs_inst (
      .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .reg_rd_unmapped, .seq_start, .conv_done, .conv_req, .conv_step,
      .conv_gain_factor, .conv_pos_kind, .conv_ext_index, .conv_neg_input7,
      .conv_neg_auto, .conv_code_unresolved, .seq_busy, .seq_done
   );

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // Hang guard: whole run needs well under this
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", exp, reg_rdata);
   endtask : rd

   task automatic start();
      @(posedge clk);
      seq_start <= 1'b1;
      @(posedge clk);
      seq_start <= 1'b0;
   endtask : start

   // Wait for a request and compare the frozen settings
   task automatic req_chk(input logic [15:0] e);
      int i;
      #1;
      for (i = 0; i < 20 && conv_req !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk("conv_req", 16'h0001, {15'h0, conv_req});
      chk("conv settings", e, {conv_step, conv_gain_factor, conv_pos_kind, conv_ext_index,
                               conv_neg_input7, conv_neg_auto, conv_code_unresolved});
   endtask : req_chk

   // One-cycle conversion done pulse
   task automatic fin();
      @(posedge clk);
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
   endtask : fin

   // Wait for a request, compare settings, then finish the conversion
   task automatic step(input logic [15:0] e);
      req_chk(e);
      fin();
   endtask : step

   // No further request may come before the done pulse
   task automatic wait_done();
      int i;
      #1;
      for (i = 0; i < 20 && seq_done !== 1'b1; i++) begin
         if (conv_req === 1'b1) chk("stray conv_req", 16'h0000, 16'h0001);
         @(posedge clk);
         #1;
      end
      chk("seq_done", 16'h0001, {15'h0, seq_done});
      chk("seq_busy", 16'h0000, {15'h0, seq_busy});
   endtask : wait_done

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'hDE, 16'h000E);
      rd(8'hDF, 16'h000F);
      // Both steps disabled after reset: done pulse only
      start();
      wait_done();
      wr(8'hDF, 16'h000F);
      for (int i = 0; i < 8; i++) begin
         wr(8'hDE, rows[i].cfg);
         rd(8'hDE, rows[i].cfg & 16'hE01F);
         start();
         step(rows[i].exp);
         wait_done();
      end
      // Unmapped address reads zero and is flagged
      rd(8'hE0, 16'h0000);
      chk("reg_rd_unmapped", 16'h0001, {15'h0, reg_rd_unmapped});
      wr(8'hDE, 16'hFFFF);
      rd(8'hDE, 16'hE01F);
      // Step 14 skipped, step 15 alone
      wr(8'hDE, 16'h001E);
      wr(8'hDF, 16'hA01F);
      start();
      step(16'hF53B);
      wait_done();
      // Done while idle is ignored
      fin();
      #1;
      chk("idle conv_req, seq_done", 16'h0000, {14'h0, conv_req, seq_done});
      // Both enabled: 14 then 15; a start while busy is ignored
      wr(8'hDE, 16'h8005);
      start();
      req_chk(16'hE228);
      start();
      fin();
      step(16'hF53B);
      wait_done();
      // Write to an unmapped address leaves both steps alone
      wr(8'hE0, 16'hFFFF);
      rd(8'hDE, 16'h8005);
      rd(8'hDF, 16'hA01F);
      // Second reset mid-run restores reset values
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'hDE, 16'h000E);
      rd(8'hDF, 16'h000F);
      give_verdict();
   end
endmodule : aux_adc_step_regs_tb_top
`default_nettype wire
